// file: idtd_decoder.sv
// Purpose: Instruction length, cycle count and operand decode with sequencing
// Assumes: Fetch shows the following word on i_next_word with each instruction
// Notes: A repeated target is assumed single cycle, as the divide steps are
`timescale 1ns/1ps
`include "idtd_regs.svh"
module idtd_decoder (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_instr_valid,
    input wire logic [`IDTD_WORD_W-1:0] i_instr,
    input wire logic [`IDTD_WORD_W-1:0] i_next_word,
    input wire logic i_exception_pending,
    input wire logic i_skip_cond,
    input wire logic i_psv_wait,
    input wire logic i_irq_accept,
    output logic o_instr_ready,
    output logic o_issue,
    output logic o_nop,
    output logic o_stall,
    output logic o_div_step,
    output idtd_pkg::idtd_decode_s o_decode
);
    idtd_pkg::idtd_state_e state;
    logic [1:0] remain;
    logic [13:0] rpt_left;
    logic rpt_armed;
    logic accept;
    idtd_pkg::idtd_fields_s new_fields;
    idtd_pkg::idtd_class_e new_cls;
    idtd_pkg::idtd_class_e next_cls_peek;
    idtd_pkg::idtd_group_e new_group;
    logic new_known;
    logic [1:0] new_words;
    logic [1:0] new_cycles;
    logic new_is_flow;
    logic flow_held;
    logic rpt_last;

    idtd_field_extract u_fields (
        .i_word(i_instr),
        .i_ext_word(i_next_word),
        .o_fields(new_fields)
    );

    // Class from the opcode byte: the group nibble and the variant nibble
    function automatic idtd_pkg::idtd_class_e classify(input logic [7:0] opc);
        idtd_pkg::idtd_class_e c;
        c = idtd_pkg::C_SINGLE;
        case (opc[7:4])
            4'h0: begin
                if (opc[3:0] == `IDTD_V_DMOVE) begin
                    c = idtd_pkg::C_TWO_CYCLE;
                end else if (opc[3:0] >= `IDTD_V_TBL_FIRST && opc[3:0] <= `IDTD_V_TBL_LAST) begin
                    c = idtd_pkg::C_TABLE;
                end
            end
            4'h1: begin
                if (opc[3:0] >= `IDTD_V_DIV_FIRST && opc[3:0] <= `IDTD_V_DIV_LAST) begin
                    c = idtd_pkg::C_DIVIDE;
                end
            end
            4'h5: begin
                if (opc[3:0] >= `IDTD_V_SKIP_FIRST) begin
                    c = idtd_pkg::C_SKIP;
                end
            end
            4'h6: begin
                case (opc[3:0])
                    `IDTD_V_CALL: c = idtd_pkg::C_CALL;
                    `IDTD_V_JUMP: c = idtd_pkg::C_JUMP;
                    `IDTD_V_LOOP: c = idtd_pkg::C_LOOP;
                    `IDTD_V_REPEAT: c = idtd_pkg::C_REPEAT;
                    4'h4, 4'h5, `IDTD_V_RET_LAST: c = idtd_pkg::C_RETURN;
                    default: c = idtd_pkg::C_BRANCH;
                endcase
            end
            4'h7: begin
                if (opc[3:0] <= `IDTD_V_STACK_LAST) begin
                    c = idtd_pkg::C_TWO_CYCLE;
                end
            end
            default: c = idtd_pkg::C_SINGLE;
        endcase
        return c;
    endfunction

    function automatic logic [1:0] words_of(input idtd_pkg::idtd_class_e c);
        logic [1:0] w;
        w = `IDTD_WORDS_ONE;
        if (c == idtd_pkg::C_CALL || c == idtd_pkg::C_JUMP || c == idtd_pkg::C_LOOP) begin
            w = `IDTD_WORDS_TWO;
        end
        return w;
    endfunction

    // Opcode bytes past the ten groups are flagged so the datapath can trap them
    always_comb begin
        new_cls = classify(i_instr[`IDTD_OPC_LSB +: 8]);
        next_cls_peek = classify(i_next_word[`IDTD_OPC_LSB +: 8]);
        new_known = (i_instr[23:20] <= 4'h9);
        new_group = new_known ? idtd_pkg::idtd_group_e'(i_instr[23:20]) : idtd_pkg::G_UNKNOWN;
        new_words = words_of(new_cls);
        new_is_flow = 1'b0;
        case (new_cls)
            idtd_pkg::C_TWO_CYCLE, idtd_pkg::C_TABLE, idtd_pkg::C_LOOP: begin
                new_cycles = `IDTD_CYC_TWO;
            end
            idtd_pkg::C_CALL, idtd_pkg::C_JUMP, idtd_pkg::C_BRANCH: begin
                new_cycles = `IDTD_CYC_TWO;
                new_is_flow = 1'b1;
            end
            idtd_pkg::C_SKIP: begin
                new_is_flow = 1'b1;
                if (!i_skip_cond) begin
                    new_cycles = `IDTD_CYC_ONE;
                end else if (words_of(next_cls_peek) == `IDTD_WORDS_TWO) begin
                    new_cycles = `IDTD_CYC_THREE;
                end else begin
                    new_cycles = `IDTD_CYC_TWO;
                end
            end
            idtd_pkg::C_RETURN: begin
                new_is_flow = 1'b1;
                new_cycles = i_exception_pending ? `IDTD_CYC_TWO : `IDTD_CYC_THREE;
            end
            default: new_cycles = `IDTD_CYC_ONE;
        endcase
    end

    assign accept = i_instr_valid && o_instr_ready;
    assign rpt_last = (rpt_left == 14'h0001);

    // Decoded instruction, held for the whole of its execution
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_decode <= '0;
            flow_held <= 1'b0;
        end else if (accept) begin
            // Kept with the decode so extra cycles follow the held op, not the word fetch shows now
            flow_held <= new_is_flow;
            o_decode.group <= new_group;
            o_decode.cls <= new_cls;
            o_decode.recognised <= new_known;
            o_decode.words <= new_words;
            o_decode.cycles <= new_cycles;
            o_decode.f <= new_fields;
        end
    end

    // Repeat count: the prefix arms it and the next instruction consumes it
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rpt_armed <= 1'b0;
            rpt_left <= 14'h0000;
        end else if (accept && new_cls == idtd_pkg::C_REPEAT) begin
            rpt_armed <= (new_fields.lit_14 != 14'h0000);
            rpt_left <= new_fields.lit_14;
        end else if (accept) begin
            rpt_armed <= 1'b0;
        end else if (state == idtd_pkg::S_REPEAT && !i_irq_accept) begin
            rpt_left <= rpt_left - 14'h0001;
        end
    end

    // Sequencer: extra cycles, forced no-ops, program-space stalls, repeat issue
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= idtd_pkg::S_IDLE;
            remain <= 2'h0;
            o_instr_ready <= 1'b1;
            o_issue <= 1'b0;
            o_nop <= 1'b0;
            o_stall <= 1'b0;
            o_div_step <= 1'b0;
        end else begin
            o_issue <= 1'b0;
            o_nop <= 1'b0;
            o_stall <= 1'b0;
            o_div_step <= 1'b0;
            case (state)
                idtd_pkg::S_IDLE: begin
                    if (accept) begin
                        o_issue <= 1'b1;
                        o_div_step <= (new_cls == idtd_pkg::C_DIVIDE);
                        if (rpt_armed) begin
                            state <= idtd_pkg::S_REPEAT;
                            o_instr_ready <= 1'b0;
                        end else if (new_cycles != `IDTD_CYC_ONE) begin
                            state <= idtd_pkg::S_EXTRA;
                            remain <= new_cycles - `IDTD_CYC_ONE;
                            o_instr_ready <= 1'b0;
                        end
                    end
                end
                idtd_pkg::S_EXTRA: begin
                    // A table access holds here while program memory is busy
                    if (o_decode.cls == idtd_pkg::C_TABLE && i_psv_wait) begin
                        o_stall <= 1'b1;
                    end else begin
                        if (flow_held) begin
                            o_nop <= 1'b1;
                        end else begin
                            o_stall <= 1'b1;
                        end
                        remain <= remain - 2'h1;
                        if (remain == 2'h1) begin
                            state <= idtd_pkg::S_IDLE;
                            o_instr_ready <= 1'b1;
                        end
                    end
                end
                idtd_pkg::S_REPEAT: begin
                    // An accepted exception freezes the count between iterations
                    if (!i_irq_accept) begin
                        o_issue <= 1'b1;
                        o_div_step <= (o_decode.cls == idtd_pkg::C_DIVIDE);
                        if (rpt_last) begin
                            state <= idtd_pkg::S_IDLE;
                            o_instr_ready <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= idtd_pkg::S_IDLE;
                    o_instr_ready <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_one_nop;
        o_nop ##1 !o_nop;
    endsequence
    sequence s_two_nops;
        o_nop ##1 o_nop ##1 !o_nop;
    endsequence

    property p_single_cycle;
        o_issue && state == idtd_pkg::S_IDLE && o_decode.cls == idtd_pkg::C_SINGLE
            |-> o_instr_ready && !o_stall && !o_nop;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("single-cycle op held the sequencer");

    property p_two_cycle;
        o_issue && o_decode.cls == idtd_pkg::C_TWO_CYCLE
            |-> !o_instr_ready ##1 (o_stall && o_instr_ready) ##1 !o_stall;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op not two cycles");

    property p_branch_nop;
        o_issue && o_decode.cls inside {idtd_pkg::C_BRANCH, idtd_pkg::C_JUMP, idtd_pkg::C_CALL}
            |-> ##1 s_one_nop;
    endproperty
    a_branch_nop: assert property (p_branch_nop) else $error("flow change missing one no-op");

    property p_skip_long;
        o_issue && o_decode.cls == idtd_pkg::C_SKIP && o_decode.cycles == `IDTD_CYC_THREE
            |-> ##1 s_two_nops;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("long skip not two no-ops");

    property p_return_cycles;
        o_issue && o_decode.cls == idtd_pkg::C_RETURN
            |-> o_decode.cycles == ($past(i_exception_pending) ? `IDTD_CYC_TWO : `IDTD_CYC_THREE);
    endproperty
    a_return_cycles: assert property (p_return_cycles) else $error("return cycle count wrong");

    property p_words;
        o_issue |-> o_decode.words == ((o_decode.cls inside {idtd_pkg::C_CALL, idtd_pkg::C_JUMP,
            idtd_pkg::C_LOOP}) ? `IDTD_WORDS_TWO : `IDTD_WORDS_ONE);
    endproperty
    a_words: assert property (p_words) else $error("word length wrong");

    property p_div_irq;
        state == idtd_pkg::S_REPEAT && i_irq_accept |=> !o_issue && !o_div_step && $stable(rpt_left);
    endproperty
    a_div_irq: assert property (p_div_irq) else $error("repeat ran through an exception");

    property p_psv_stall;
        state == idtd_pkg::S_EXTRA && o_decode.cls == idtd_pkg::C_TABLE && i_psv_wait
            |=> o_stall && !o_instr_ready;
    endproperty
    a_psv_stall: assert property (p_psv_stall) else $error("program-space wait not stalled");

    property p_byte_lit;
        o_issue && o_decode.f.byte_mode |-> o_decode.f.ten_bit_unsigned_literal[9:8] == 2'h0;
    endproperty
    a_byte_lit: assert property (p_byte_lit) else $error("byte-mode literal above 255");

    property p_sign_ext;
        o_issue |-> o_decode.f.signed_offset_literal[15:9] inside {7'h00, 7'h7F};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("offset literal not sign extended");
endmodule // idtd_decoder

// file: idtd_regs.svh
// Purpose: Constants for the instruction timing and operand decoder
// Assumes: 24-bit instruction words, opcode in the top byte
// Notes: Field positions are shared by the field extractor and sequencer
// Behaviour
// - Instruction words are 24 bits; length counts whole words
// - Recognise the base set in ten functional groups
// - Non-listed instructions complete in exactly one cycle
// - Loop setup, double move/pull/push, table reads/writes take two cycles
// - Divide steps are single cycle, repeated 18 times under repeat prefix
// - Program counter changes take two cycles, extra one is a no-op
// - Skip over a two-word instruction takes three cycles, two no-ops
// - Returns take three cycles, two when an exception is pending
// - Call, loop setup and absolute jump occupy two words, others one
// - Each addressing variant has its own opcode, told apart by it
// - Unsigned literals of 1..23 bits are zero-based ranges
// - Ten-bit literal spans 0..255 in byte mode, 0..1023 in word mode
// - Signed 4, 10 and 16-bit literals are sign extended
// - Bit instructions carry a 4-bit bit position 0..15
// - Divide: first register is dividend, second is divisor
// - Signal-processing ops carry X/Y prefetch source and destination fields
// - Program-space data reads stall the sequencer for extra cycles
// - Repeat prefix adds one cycle; divide iterations are interruptible
`ifndef IDTD_REGS_SVH
`define IDTD_REGS_SVH
`define IDTD_WORD_W 24
`define IDTD_OPC_LSB 16
`define IDTD_EXT_W 7
`define IDTD_LIT_LSB 4
`define IDTD_BITPOS_LSB 12
`define IDTD_BYTE_MODE_BIT 14
`define IDTD_WS_LSB 0
`define IDTD_WD_LSB 7
`define IDTD_WB_LSB 11
`define IDTD_XSRC_LSB 12
`define IDTD_YSRC_LSB 8
`define IDTD_XDST_LSB 6
`define IDTD_YDST_LSB 4
`define IDTD_CYC_ONE 2'h1
`define IDTD_CYC_TWO 2'h2
`define IDTD_CYC_THREE 2'h3
`define IDTD_WORDS_ONE 2'h1
`define IDTD_WORDS_TWO 2'h2
`define IDTD_V_TBL_FIRST 4'hA
`define IDTD_V_TBL_LAST 4'hD
`define IDTD_V_DMOVE 4'hE
`define IDTD_V_DIV_FIRST 4'h8
`define IDTD_V_DIV_LAST 4'hA
`define IDTD_V_SKIP_FIRST 4'h8
`define IDTD_V_CALL 4'h0
`define IDTD_V_JUMP 4'h1
`define IDTD_V_LOOP 4'h2
`define IDTD_V_REPEAT 4'h3
`define IDTD_V_RET_LAST 4'h6
`define IDTD_V_STACK_LAST 4'h1
`endif

// file: idtd_pkg.sv
// Purpose: Types for the instruction timing and operand decoder
// Assumes: Group codes follow the opcode high nibble in order
// Notes: Constants live in idtd_regs.svh
package idtd_pkg;
    typedef enum logic [3:0] {G_MOVE, G_MATH, G_LOGIC, G_ROTATE, G_BIT, G_CMP_SKIP,
        G_FLOW, G_STACK, G_CONTROL, G_SIGNAL, G_UNKNOWN} idtd_group_e;
    typedef enum logic [3:0] {C_SINGLE, C_TWO_CYCLE, C_TABLE, C_DIVIDE, C_REPEAT, C_LOOP,
        C_CALL, C_JUMP, C_BRANCH, C_SKIP, C_RETURN} idtd_class_e;
    typedef enum logic [1:0] {S_IDLE, S_EXTRA, S_REPEAT} idtd_state_e;
    typedef struct packed {
        logic lit_1;
        logic [3:0] lit_4;
        logic [4:0] lit_5;
        logic [7:0] lit_8;
        logic [9:0] ten_bit_unsigned_literal;
        logic [13:0] lit_14;
        logic [15:0] lit_16;
        logic [22:0] widest_unsigned_literal;
        logic [15:0] small_signed_literal;
        logic [15:0] signed_offset_literal;
        logic [15:0] wide_signed_literal;
        logic [3:0] bit_position_field;
        logic [3:0] src_reg;
        logic [3:0] dst_reg;
        logic [3:0] base_reg;
        logic [3:0] dividend_reg;
        logic [3:0] divisor_reg;
        logic [3:0] x_bus_prefetch_source;
        logic [3:0] y_bus_prefetch_source;
        logic [1:0] x_prefetch_dest;
        logic [1:0] y_prefetch_dest;
        logic byte_mode;
    } idtd_fields_s;
    typedef struct packed {
        idtd_group_e group;
        idtd_class_e cls;
        logic recognised;
        logic [1:0] words;
        logic [1:0] cycles;
        idtd_fields_s f;
    } idtd_decode_s;
endpackage

// file: idtd_field_extract.sv
// Purpose: Operand field extraction for one instruction word
// Assumes: Second word is valid only for two-word instructions
// Notes: Purely combinational; the sequencer registers the result
`timescale 1ns/1ps
`include "idtd_regs.svh"
module idtd_field_extract (
    input wire logic [`IDTD_WORD_W-1:0] i_word,
    input wire logic [`IDTD_WORD_W-1:0] i_ext_word,
    output idtd_pkg::idtd_fields_s o_fields
);
    logic [9:0] raw10;
    logic [3:0] raw4;
    logic [15:0] raw16;
    logic bmode;

    assign raw10 = i_word[`IDTD_LIT_LSB +: 10];
    assign raw4 = i_word[3:0];
    assign raw16 = i_word[`IDTD_LIT_LSB +: 16];
    assign bmode = i_word[`IDTD_BYTE_MODE_BIT];

    always_comb begin
        o_fields = '0;
        o_fields.lit_1 = i_word[0];
        o_fields.lit_4 = raw4;
        o_fields.lit_5 = i_word[4:0];
        o_fields.lit_8 = i_word[`IDTD_LIT_LSB +: 8];
        o_fields.lit_14 = i_word[13:0];
        o_fields.lit_16 = raw16;
        // Upper bits of the widest literal ride in the second word
        o_fields.widest_unsigned_literal = {i_ext_word[`IDTD_EXT_W-1:0], i_word[15:0]};
        // Byte mode keeps only the low byte so the value cannot pass 255
        o_fields.ten_bit_unsigned_literal = bmode ? {2'h0, raw10[7:0]} : raw10;
        o_fields.byte_mode = bmode;
        o_fields.small_signed_literal = {{12{raw4[3]}}, raw4};
        o_fields.signed_offset_literal = {{6{raw10[9]}}, raw10};
        o_fields.wide_signed_literal = raw16;
        o_fields.bit_position_field = i_word[`IDTD_BITPOS_LSB +: 4];
        o_fields.src_reg = i_word[`IDTD_WS_LSB +: 4];
        o_fields.dst_reg = i_word[`IDTD_WD_LSB +: 4];
        o_fields.base_reg = i_word[`IDTD_WB_LSB +: 4];
        o_fields.dividend_reg = i_word[`IDTD_WB_LSB +: 4];
        o_fields.divisor_reg = i_word[`IDTD_WS_LSB +: 4];
        o_fields.x_bus_prefetch_source = i_word[`IDTD_XSRC_LSB +: 4];
        o_fields.y_bus_prefetch_source = i_word[`IDTD_YSRC_LSB +: 4];
        o_fields.x_prefetch_dest = i_word[`IDTD_XDST_LSB +: 2];
        o_fields.y_prefetch_dest = i_word[`IDTD_YDST_LSB +: 2];
    end
endmodule // idtd_field_extract

// file: idtd_fetch_model.sv
// Purpose: Fetch unit model feeding the instruction decoder
// Assumes: Entries are pushed by the bench a little after a clock edge
// Notes: Words stay on the bus until taken; a released bus shows inverted data
`timescale 1ns/1ps
`include "idtd_regs.svh"
module idtd_fetch_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_instr_ready,
    output logic o_instr_valid,
    output logic [`IDTD_WORD_W-1:0] o_instr,
    output logic [`IDTD_WORD_W-1:0] o_next_word,
    output logic o_psv_wait
);
    logic [2*`IDTD_WORD_W-1:0] q[$];
    int psv_q[$];
    int psv_left = 0;
    task automatic push(input logic [`IDTD_WORD_W-1:0] w, input logic [`IDTD_WORD_W-1:0] nx, input int psv);
        q.push_back({w, nx});
        psv_q.push_back(psv);
    endtask
    initial begin
        o_instr_valid = 1'b0;
        o_instr = '0;
        o_next_word = '0;
        o_psv_wait = 1'b0;
    end
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_instr_valid <= 1'b0;
            o_psv_wait <= 1'b0;
            psv_left = 0;
        end else begin
            if (o_instr_valid && i_instr_ready) begin
                void'(q.pop_front());
                psv_left = psv_q.pop_front();
            end
            // Program memory stays busy for the requested count after a table access
            o_psv_wait <= (psv_left > 0);
            if (psv_left > 0)
                psv_left--;
            if (q.size() > 0) begin
                // Second word travels with the first, as two-word ops need
                o_instr_valid <= 1'b1;
                o_instr <= q[0][2*`IDTD_WORD_W-1:`IDTD_WORD_W];
                o_next_word <= q[0][`IDTD_WORD_W-1:0];
            end else begin
                // Idle bus never holds a stale word that could be mistaken for a request
                o_instr_valid <= 1'b0;
                o_instr <= ~o_instr;
                o_next_word <= ~o_next_word;
            end
        end
    end
endmodule // idtd_fetch_model

// file: tb.sv
// Purpose: Self-checking bench for the instruction decoder
// Assumes: Opcode map and field positions as set by the design constants
// Notes: Pulses are counted per run; totals are compared with computed counts
`timescale 1ns/1ps
`include "idtd_regs.svh"
module tb;
    logic i_clk = 0;
    logic i_reset_n = 0;
    logic i_exception_pending = 0;
    logic i_skip_cond = 0;
    logic i_irq_accept = 0;
    logic i_instr_valid;
    logic i_psv_wait;
    logic [`IDTD_WORD_W-1:0] i_instr;
    logic [`IDTD_WORD_W-1:0] i_next_word;
    logic o_instr_ready;
    logic o_issue;
    logic o_nop;
    logic o_stall;
    logic o_div_step;
    idtd_pkg::idtd_decode_s o_decode;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 92;
    int n_iss, n_nop, n_stl, n_div;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_issue === 1'b1) n_iss++;
        if (o_nop === 1'b1) n_nop++;
        if (o_stall === 1'b1) n_stl++;
        if (o_div_step === 1'b1) n_div++;
    end
    idtd_fetch_model u_idtd_fetch_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_ready(o_instr_ready),
        .o_instr_valid(i_instr_valid), .o_instr(i_instr), .o_next_word(i_next_word), .o_psv_wait(i_psv_wait));
    idtd_decoder u_idtd_decoder (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_next_word(i_next_word), .i_exception_pending(i_exception_pending),
        .i_skip_cond(i_skip_cond), .i_psv_wait(i_psv_wait), .i_irq_accept(i_irq_accept),
        .o_instr_ready(o_instr_ready), .o_issue(o_issue), .o_nop(o_nop), .o_stall(o_stall),
        .o_div_step(o_div_step), .o_decode(o_decode));
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Packs {no-op count, stall count}; psv overhead is not included
    function automatic logic [3:0] exp_extra(input logic [23:0] w, input logic [23:0] nx, input logic exc,
        input logic skip);
        logic [3:0] g;
        logic [3:0] v;
        g = w[23:20];
        v = w[19:16];
        if ((g == 4'h0 && v >= 4'hA && v <= 4'hE) || (g == 4'h7 && v <= 4'h1) || (g == 4'h6 && v == 4'h2))
            return 4'h1;
        if (g == 4'h6 && v >= 4'h4 && v <= 4'h6)
            return exc ? 4'h4 : 4'h8;
        if (g == 4'h6 && v != 4'h3)
            return 4'h4;
        if (g == 4'h5 && v >= 4'h8 && skip)
            return (nx[23:16] >= 8'h60 && nx[23:16] <= 8'h62) ? 4'h8 : 4'h4;
        return 4'h0;
    endfunction
    task automatic settle;
        int k;
        for (k = 0; k < 300 && !(u_idtd_fetch_model.q.size() == 0 && o_instr_ready === 1'b1); k++)
            @(posedge i_clk) #1;
        if (k == 300) begin
            num_errors++;
            $display("[FAIL] ready wait expected 1 seen timeout");
            give_verdict();
        end
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic start(input logic exc, input logic skip);
        @(posedge i_clk);
        i_exception_pending <= exc;
        i_skip_cond <= skip;
        #1;
        n_iss = 0;
        n_nop = 0;
        n_stl = 0;
        n_div = 0;
    endtask
    task automatic check_one(input logic [23:0] w, input logic [23:0] nx, input logic exc, input logic skip);
        logic [3:0] e;
        logic two;
        e = exp_extra(w, nx, exc, skip);
        two = (w[23:16] >= 8'h60 && w[23:16] <= 8'h62);
        start(exc, skip);
        u_idtd_fetch_model.push(w, nx, 0);
        settle();
        cmp_val("issue count", 1, n_iss);
        cmp_val("nop count", e[3:2], n_nop);
        cmp_val("stall count", e[1:0], n_stl);
        cmp_val("div steps", w[23:16] >= 8'h18 && w[23:16] <= 8'h1A, n_div);
        cmp_val("cycles", 1 + e[3:2] + e[1:0], o_decode.cycles);
        cmp_val("words", two ? 2 : 1, o_decode.words);
        cmp_val("group", w[23:20] > 4'h9 ? 4'hA : w[23:20], o_decode.group);
        cmp_val("recognised", w[23:20] <= 4'h9, o_decode.recognised);
        if (two)
            cmp_val("widest literal", {nx[6:0], w[15:0]}, o_decode.f.widest_unsigned_literal);
        cmp_val("lit14", w[13:0], o_decode.f.lit_14);
        cmp_val("small literals", {w[0], w[3:0], w[4:0], w[11:4]}, {o_decode.f.lit_1, o_decode.f.lit_4,
            o_decode.f.lit_5, o_decode.f.lit_8});
        cmp_val("lit16", {w[19:4], w[19:4]}, {o_decode.f.lit_16, o_decode.f.wide_signed_literal});
        cmp_val("ten_bit_unsigned_literal", w[14] ? {2'h0, w[11:4]} : w[13:4], o_decode.f.ten_bit_unsigned_literal);
        cmp_val("mode and registers", {w[14], w[3:0], w[10:7], w[14:11]}, {o_decode.f.byte_mode,
            o_decode.f.src_reg, o_decode.f.dst_reg, o_decode.f.base_reg});
        cmp_val("signed4", {{12{w[3]}}, w[3:0]}, o_decode.f.small_signed_literal);
        cmp_val("signed10", {{6{w[13]}}, w[13:4]}, o_decode.f.signed_offset_literal);
        cmp_val("bit position", w[15:12], o_decode.f.bit_position_field);
        cmp_val("dividend", w[14:11], o_decode.f.dividend_reg);
        cmp_val("divisor", w[3:0], o_decode.f.divisor_reg);
        cmp_val("xy fields", {w[15:8], w[7:4]}, {o_decode.f.x_bus_prefetch_source,
            o_decode.f.y_bus_prefetch_source, o_decode.f.x_prefetch_dest, o_decode.f.y_prefetch_dest});
    endtask
    initial begin
        logic [23:0] w;
        logic [23:0] nx;
        int ex_nop, ex_stl, ex_div;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        #1;
        cmp_val("ready after reset", 1, o_instr_ready);
        cmp_val("decode after reset", 1, o_decode === '0);
        // Every variant of every group except the repeat prefix, plain and with an exception and a two-word follower
        for (int e = 0; e < 2; e++) begin
            for (int g = 0; g < 16; g++) begin
                for (int v = 0; v < 16; v++) begin
                    w = {4'(g), 4'(v), 16'($random(seed))};
                    nx = 24'($random(seed));
                    if (e == 1)
                        nx[23:16] = 8'h60 + 8'(v % 3);
                    if (w[23:16] != 8'h63)
                        check_one(w, nx, e[0], w[16]);
                end
            end
        end
        $display("decode sweep done: compared %0d", n_compared);
        // Repeated divide steps, held by exception cycles; count 0 runs the target once
        for (int d = 8; d < 11; d++) begin
            start(1'b0, 1'b0);
            u_idtd_fetch_model.push({8'h63, 2'h0, (d == 8) ? 14'h0 : 14'h11}, 24'($random(seed)), 0);
            u_idtd_fetch_model.push({8'h10 | 8'(d), 16'($random(seed))}, 24'($random(seed)), 0);
            repeat (6) @(posedge i_clk);
            i_irq_accept <= 1'b1;
            repeat (2) @(posedge i_clk);
            i_irq_accept <= 1'b0;
            #1;
            settle();
            cmp_val("repeat issues", (d == 8) ? 2 : 19, n_iss);
            cmp_val("repeat div steps", (d == 8) ? 1 : 18, n_div);
            $display("repeat done: issues %0d", n_iss);
        end
        // Table read with program memory busy
        start(1'b0, 1'b0);
        u_idtd_fetch_model.push({8'h0B, 16'($random(seed))}, 24'($random(seed)), 3);
        settle();
        // Three busy cycles stretch the table's one extra cycle, four stalls in all
        cmp_val("psv stall stretch", 4, n_stl);
        cmp_val("psv nops", 0, n_nop);
        $display("table wait done: stalls %0d", n_stl);
        // Random back-to-back stream with exception and skip held true
        start(1'b1, 1'b1);
        ex_nop = 0;
        ex_stl = 0;
        ex_div = 0;
        for (int i = 0; i < 40; i++) begin
            w = 24'($random(seed));
            if (w[23:16] == 8'h63)
                w[16] = 1'b0;
            nx = 24'($random(seed));
            ex_nop += exp_extra(w, nx, 1'b1, 1'b1) >> 2;
            ex_stl += exp_extra(w, nx, 1'b1, 1'b1) & 4'h3;
            ex_div += (w[23:16] >= 8'h18 && w[23:16] <= 8'h1A);
            u_idtd_fetch_model.push(w, nx, 0);
        end
        settle();
        $display("stream done: issues %0d", n_iss);
        cmp_val("stream issues", 40, n_iss);
        cmp_val("stream nops", ex_nop, n_nop);
        cmp_val("stream stalls", ex_stl, n_stl);
        cmp_val("stream div steps", ex_div, n_div);
        give_verdict();
    end
endmodule // tb
